// ### dv/tb_top.sv
// Self-checking bench for the zero-extend unit
`timescale 1ns/10ps
module tb_top;
  import zxa_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0, gen = 1'b0, req = 1'b0, lden;
  logic [OPC_W-1:0] opc = 8'h00;
  logic [SLOT_W-1:0] slot = 3'h0;
  logic [REG_IDX_W-1:0] src = 7'h00, grd = 7'h00, dst = 7'h00, rreg = 7'h00, obsr = 7'h00, ldreg;
  logic [DATA_W-1:0] rdat = 32'h0000_0000, lddat, obsd, res, d;
  logic done, wrote, rej;
  int mismatches = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  zxa_load_model zxa_load_model_inst (.req_in(req), .req_reg_in(rreg), .req_data_in(rdat),
    .load_en_out(lden), .load_reg_out(ldreg), .load_data_out(lddat));
  zxa_unit zxa_unit_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .issue_valid_in(vld), .issue_opcode_in(opc),
    .issue_slot_in(slot), .source_reg_a_in(src), .guard_en_in(gen), .guard_reg_in(grd), .dest_reg_in(dst),
    .load_en_in(lden), .load_reg_in(ldreg), .load_data_in(lddat), .obs_reg_in(obsr), .obs_data_out(obsd),
    .result_out(res), .done_out(done), .wrote_out(wrote), .reject_out(rej));
  task automatic complete_run();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic ld(input logic [6:0] r, input logic [31:0] v);
    @(negedge clk) {req, rreg, rdat} = {1'b1, r, v};
    @(negedge clk) req = 1'b0;
  endtask : ld
  task automatic op(input logic [7:0] o, input logic [2:0] s, input logic [6:0] a, input logic g,
      input logic [6:0] gr, input logic [6:0] de);
    @(negedge clk) {vld, opc, slot, src, gen, grd, dst} = {1'b1, o, s, a, g, gr, de};
    @(negedge clk) vld = 1'b0;
  endtask : op
  task automatic rd(input logic [6:0] r);
    @(negedge clk) obsr = r;
    @(negedge clk) d = obsd;
  endtask : rd
  task automatic t_half();
    ld(7'h05, 32'hffff_0040);
    op(OPC_HALF_ZEXT, 3'h1, 7'h05, 1'b0, 7'h00, 7'h06);
    chk("half result", 32'h0000_0040, res);
    chk("half flags", 32'h3, {done, wrote});
    rd(7'h06);
    chk("half dest", 32'h0000_0040, d);
    $display("test half done");
  endtask : t_half
  task automatic t_byte();
    ld(7'h07, 32'hff0f_ff91);
    op(OPC_BYTE_ZEXT, 3'h5, 7'h07, 1'b0, 7'h00, 7'h08);
    chk("byte result", 32'h0000_0091, res);
    rd(7'h08);
    chk("byte dest", 32'h0000_0091, d);
    $display("test byte done");
  endtask : t_byte
  task automatic t_guard();
    ld(7'h0a, 32'hffff_fffe);
    op(OPC_HALF_ZEXT, 3'h3, 7'h07, 1'b1, 7'h0a, 7'h08);
    chk("false guard flags", 32'h2, {done, wrote});
    rd(7'h08);
    chk("false guard dest", 32'h0000_0091, d);
    ld(7'h0b, 32'h0000_0001);
    op(OPC_HALF_ZEXT, 3'h2, 7'h07, 1'b1, 7'h0b, 7'h08);
    chk("true guard flags", 32'h3, {done, wrote});
    rd(7'h08);
    chk("true guard dest", 32'h0000_ff91, d);
    op(OPC_HALF_ZEXT, 3'h1, 7'h07, 1'b1, 7'h00, 7'h08);
    chk("zero guard flags", 32'h2, {done, wrote});
    $display("test guard done");
  endtask : t_guard
  task automatic t_codes();
    for (int s = 0; s < 8; s++) begin
      op((s % 2) ? OPC_BYTE_ZEXT : OPC_HALF_ZEXT, 3'(s), 7'h05, 1'b0, 7'h00, 7'h09);
      chk("slot flags", (s >= 1 && s <= 5) ? 32'h2 : 32'h1, {done, rej});
    end
    op(8'h36, 3'h1, 7'h05, 1'b0, 7'h00, 7'h09);
    chk("bad code flags", 32'h1, {done, rej});
    $display("test codes done");
  endtask : t_codes
  task automatic t_zero();
    op(OPC_HALF_ZEXT, 3'h4, 7'h05, 1'b0, 7'h00, 7'h00);
    ld(7'h00, 32'h1234_5678);
    rd(7'h00);
    chk("zero reg", DATA_ZERO, d);
    op(OPC_BYTE_ZEXT, 3'h1, 7'h00, 1'b0, 7'h00, 7'h0c);
    chk("zero source", DATA_ZERO, res);
    $display("test zero done");
  endtask : t_zero
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_half();
    t_byte();
    t_guard();
    t_codes();
    t_zero();
    complete_run();
  end
endmodule : tb_top

// ### dv/zxa_load_model.sv
// Register load source standing in for the other units
`timescale 1ns/10ps
module zxa_load_model
  import zxa_pkg::*;
(
  // Request from the bench
  input wire logic req_in,
  input wire logic [REG_IDX_W-1:0] req_reg_in,
  input wire logic [DATA_W-1:0] req_data_in,
  // Load port
  output logic load_en_out,
  output logic [REG_IDX_W-1:0] load_reg_out,
  output logic [DATA_W-1:0] load_data_out
);
  // Idle data shows the inverse so no stale value passes for a load
  assign load_en_out = req_in;
  assign load_reg_out = req_reg_in;
  assign load_data_out = req_in ? req_data_in : ~req_data_in;
endmodule : zxa_load_model

// ### hdl/zxa_alu.sv
// Pack and byte-select datapath that carries out both extend operations
`timescale 1ns/10ps
module zxa_alu
  import zxa_pkg::*;
(
  // Operands in, result out
  zxa_alu_if.alu op
);
  // Low halves of both operands, first operand on top
  function automatic logic [DATA_W-1:0] zxa_low_halfword_pack(input logic [DATA_W-1:0] a,
                                                              input logic [DATA_W-1:0] b);
    zxa_low_halfword_pack = {a[HALF_W-1:0], b[HALF_W-1:0]};
  endfunction : zxa_low_halfword_pack

  // Byte of b picked by low bits of a, zero filled
  function automatic logic [DATA_W-1:0] zxa_ubyte_select(input logic [DATA_W-1:0] a,
                                                         input logic [DATA_W-1:0] b);
    logic [SEL_W-1:0] sel;
    sel = a[SEL_W-1:0];
    zxa_ubyte_select = {{(DATA_W-BYTE_W){1'b0}}, b[sel*BYTE_W +: BYTE_W]};
  endfunction : zxa_ubyte_select

  wire [DATA_W-1:0] pack_w = zxa_low_halfword_pack(op.opnd_a, op.opnd_b); // RQ4
  wire [DATA_W-1:0] bsel_w = zxa_ubyte_select(op.opnd_a, op.opnd_b); // RQ5

  assign op.result = (op.kind == ZXA_KIND_HALF) ? pack_w :
                     (op.kind == ZXA_KIND_BYTE) ? bsel_w : DATA_ZERO;
endmodule : zxa_alu

// ### hdl/zxa_alu_if.sv
// Operand and result carrier between issue control and the extend datapath
`timescale 1ns/10ps
interface zxa_alu_if;
  import zxa_pkg::*;
  logic [DATA_W-1:0] opnd_a;
  logic [DATA_W-1:0] opnd_b;
  zxa_kind_e kind;
  logic [DATA_W-1:0] result;
  modport ctl (output opnd_a, output opnd_b, output kind, input result);
  modport alu (input opnd_a, input opnd_b, input kind, output result);
endinterface : zxa_alu_if

// ### hdl/zxa_pkg.sv
// Constants and types for the zero-extend ALU operations
package zxa_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned OPC_W = 8;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned REG_IDX_W = 7;
  localparam int unsigned NUM_REGS = 128;
  localparam int unsigned SEL_W = 2;
  localparam logic [OPC_W-1:0] OPC_HALF_ZEXT = 8'h35;
  localparam logic [OPC_W-1:0] OPC_BYTE_ZEXT = 8'h37;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  localparam logic [REG_IDX_W-1:0] ZERO_REG_IDX = 7'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam int unsigned GUARD_BIT = 0;

  typedef enum logic [2:0] {
    ZXA_KIND_NONE = 3'b001,
    ZXA_KIND_HALF = 3'b010,
    ZXA_KIND_BYTE = 3'b100
  } zxa_kind_e;
endpackage : zxa_pkg

// ### hdl/zxa_unit.sv
// Guarded zero-extend ALU operations with their general register file
//
// Behaviour
// RQ1 - Halfword extend: source bits 15..0 to low half, upper 16 bits zero.
// RQ2 - Byte extend: source bits 7..0 to lowest byte, all other bits zero.
// RQ3 - With a guard, destination written only when guard bit 0 is 1.
// RQ4 - Halfword extend runs as low halfword pack, zero first, source second.
// RQ5 - Byte extend runs as unsigned byte select, zero register first, source second.
// RQ6 - General register zero always reads as zero.
// RQ7 - Codes 53 and 55, one source operand, legal in slots 1 to 5.
// RQ8 - Result one cycle after issue; unguarded operations always write.
`timescale 1ns/10ps
module zxa_unit
  import zxa_pkg::*;
#(
  parameter int unsigned REGS = NUM_REGS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Issue slot
  input wire logic issue_valid_in,
  input wire logic [OPC_W-1:0] issue_opcode_in,
  input wire logic [SLOT_W-1:0] issue_slot_in,
  input wire logic [REG_IDX_W-1:0] source_reg_a_in,
  input wire logic guard_en_in,
  input wire logic [REG_IDX_W-1:0] guard_reg_in,
  input wire logic [REG_IDX_W-1:0] dest_reg_in,
  // Register load from other units
  input wire logic load_en_in,
  input wire logic [REG_IDX_W-1:0] load_reg_in,
  input wire logic [DATA_W-1:0] load_data_in,
  // Register observe port
  input wire logic [REG_IDX_W-1:0] obs_reg_in,
  output logic [DATA_W-1:0] obs_data_out,
  // Operation status
  output logic [DATA_W-1:0] result_out,
  output logic done_out,
  output logic wrote_out,
  output logic reject_out
);
  logic [DATA_W-1:0] regs [REGS];
  logic [DATA_W-1:0] result_r;
  logic done_r;
  logic wrote_r;
  logic reject_r;
  logic [DATA_W-1:0] obs_data_r;

  // Register read with register zero pinned to zero
  function automatic logic [DATA_W-1:0] zxa_read(input logic [REG_IDX_W-1:0] idx,
                                                 input logic [DATA_W-1:0] val);
    zxa_read = (idx == ZERO_REG_IDX) ? DATA_ZERO : val; // RQ6
  endfunction : zxa_read

  // Opcode to operation kind
  function automatic zxa_kind_e zxa_decode(input logic [OPC_W-1:0] opc);
    zxa_decode = (opc == OPC_HALF_ZEXT) ? ZXA_KIND_HALF :
                 (opc == OPC_BYTE_ZEXT) ? ZXA_KIND_BYTE : ZXA_KIND_NONE; // RQ7
  endfunction : zxa_decode

  zxa_alu_if alu_bus ();

  wire [DATA_W-1:0] src_val_w = zxa_read(source_reg_a_in, regs[source_reg_a_in]);
  wire [DATA_W-1:0] guard_val_w = zxa_read(guard_reg_in, regs[guard_reg_in]);
  wire [DATA_W-1:0] zero_val_w = zxa_read(ZERO_REG_IDX, regs[ZERO_REG_IDX]); // RQ6
  wire zxa_kind_e kind_w = zxa_decode(issue_opcode_in);
  wire slot_ok_w = (issue_slot_in >= SLOT_FIRST) && (issue_slot_in <= SLOT_LAST); // RQ7
  wire legal_w = (kind_w != ZXA_KIND_NONE) && slot_ok_w; // RQ7
  wire exec_w = issue_valid_in && legal_w;
  wire guard_ok_w = !guard_en_in || guard_val_w[GUARD_BIT]; // RQ3
  wire write_w = exec_w && guard_ok_w; // RQ3 RQ8
  wire op_wr_w = write_w && (dest_reg_in != ZERO_REG_IDX);
  wire load_wr_w = load_en_in && (load_reg_in != ZERO_REG_IDX);

  // Zero register as first operand, source as second
  assign alu_bus.opnd_a = zero_val_w; // RQ4 RQ5
  assign alu_bus.opnd_b = src_val_w;
  assign alu_bus.kind = kind_w;

  zxa_alu u_alu (
    .op (alu_bus)
  );

  // Register file; the operation's write wins over a load to the same register
  always_ff @(posedge sys_clk_in) begin
    if (load_wr_w) begin
      regs[load_reg_in] <= load_data_in;
    end
    if (op_wr_w) begin
      regs[dest_reg_in] <= alu_bus.result; // RQ1 RQ2 RQ8
    end
  end

  // Status and result, one cycle after issue
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result_r <= DATA_ZERO;
      done_r <= 1'b0;
      wrote_r <= 1'b0;
      reject_r <= 1'b0;
      obs_data_r <= DATA_ZERO;
    end else begin
      done_r <= exec_w; // RQ8
      wrote_r <= write_w; // RQ3
      reject_r <= issue_valid_in && !legal_w; // RQ7
      obs_data_r <= zxa_read(obs_reg_in, regs[obs_reg_in]); // RQ6
      if (exec_w) begin
        result_r <= alu_bus.result; // RQ8
      end
    end
  end

  assign result_out = result_r;
  assign done_out = done_r;
  assign wrote_out = wrote_r;
  assign reject_out = reject_r;
  assign obs_data_out = obs_data_r;

  // Checks
  wire half_go_w = exec_w && (kind_w == ZXA_KIND_HALF);
  wire byte_go_w = exec_w && (kind_w == ZXA_KIND_BYTE);

  a_half_result: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ1
    half_go_w |=> result_out == {16'h0000, $past(src_val_w[HALF_W-1:0])})
    else $error("halfword extend result wrong");

  a_byte_result: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ2
    byte_go_w |=> result_out == {24'h00_0000, $past(src_val_w[BYTE_W-1:0])})
    else $error("byte extend result wrong");

  a_guard_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ3
    exec_w && guard_en_in && !guard_val_w[GUARD_BIT] |=> done_out && !wrote_out)
    else $error("false guard still wrote");

  a_guard_keeps_dest: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ3
    exec_w && guard_en_in && !guard_val_w[GUARD_BIT] && !load_en_in && (obs_reg_in == dest_reg_in)
    ##1 (obs_reg_in == $past(dest_reg_in)) |=> obs_data_out == $past(obs_data_out))
    else $error("false guard changed destination");

  a_pack_operands: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ4
    half_go_w |-> alu_bus.opnd_a == DATA_ZERO && alu_bus.opnd_b == src_val_w)
    else $error("pack operands not zero and source");

  a_bsel_operands: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ5
    byte_go_w |-> alu_bus.opnd_a == DATA_ZERO && alu_bus.opnd_b == src_val_w)
    else $error("byte select operands not zero and source");

  a_zero_reg_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ6
    obs_reg_in == ZERO_REG_IDX |=> obs_data_out == DATA_ZERO)
    else $error("register zero not zero");

  a_opcode_slot_check: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ7
    issue_valid_in && (issue_slot_in == 3'h0 || issue_slot_in > 3'h5 ||
    (issue_opcode_in != 8'h35 && issue_opcode_in != 8'h37)) |=> reject_out && !done_out && !wrote_out)
    else $error("illegal opcode or slot executed");

  a_unguarded_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
    exec_w && !guard_en_in |=> done_out && wrote_out)
    else $error("unguarded operation did not write");

  a_one_cycle_latency: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
    done_out |-> $past(issue_valid_in) && !reject_out)
    else $error("done without issue one cycle before");

  a_written_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
    op_wr_w && (obs_reg_in == dest_reg_in) ##1 (obs_reg_in == $past(dest_reg_in))
    |=> obs_data_out == $past(result_out))
    else $error("destination not updated with result");

  a_half_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ1
    half_go_w |=> result_out[DATA_W-1:HALF_W] == 16'h0000)
    else $error("halfword extend upper half not zero");

  a_byte_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ2
    byte_go_w |=> result_out[DATA_W-1:BYTE_W] == 24'h00_0000)
    else $error("byte extend upper bits not zero");

  a_guard_true_writes: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ3
    exec_w && guard_en_in && guard_val_w[GUARD_BIT] |=> done_out && wrote_out)
    else $error("true guard did not write");

  a_wrote_needs_done: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ3
    wrote_out |-> done_out)
    else $error("write reported without an executed operation");

  a_pack_result_form: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ4
    half_go_w |-> alu_bus.result == {16'h0000, src_val_w[HALF_W-1:0]})
    else $error("pack did not give zero over source low half");

  a_bsel_result_form: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ5
    byte_go_w |-> alu_bus.result == {24'h00_0000, src_val_w[BYTE_W-1:0]})
    else $error("byte select did not pick source low byte");

  a_zero_source: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ6
    exec_w && (source_reg_a_in == ZERO_REG_IDX) |=> result_out == DATA_ZERO)
    else $error("register zero as source gave nonzero result");

  a_zero_guard_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ6
    exec_w && guard_en_in && (guard_reg_in == ZERO_REG_IDX) |=> done_out && !wrote_out)
    else $error("guard on register zero still wrote");

  a_legal_issue_runs: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ7
    issue_valid_in && issue_slot_in >= 3'h1 && issue_slot_in <= 3'h5 &&
    (issue_opcode_in == 8'h35 || issue_opcode_in == 8'h37) |=> done_out && !reject_out)
    else $error("legal operation not executed");

  a_slot_reject: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ7
    issue_valid_in && (issue_slot_in < SLOT_FIRST || issue_slot_in > SLOT_LAST) |=> reject_out && !done_out)
    else $error("operation in illegal slot not rejected");

  a_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
    !issue_valid_in |=> !done_out && !wrote_out && !reject_out)
    else $error("status pulse without issue");

  a_result_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
    !exec_w |=> $stable(result_out))
    else $error("result changed without an executed operation");

  c_half_op: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) half_go_w ##1 wrote_out);
  c_byte_op: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) byte_go_w ##1 wrote_out);
  c_guard_false: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) done_out && !wrote_out);
  c_reject: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) reject_out);
  c_guard_true: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) exec_w && guard_en_in ##1 wrote_out);
endmodule : zxa_unit
